// ---- pkg/sgt_pkg.sv ----
// How it works
// - Enabled guard timer resets the system or raises an interrupt, per mode, when software misses the reload deadline.
// - Enable is set by software; only reset or own expiry/fault clears it.
// - Wrong or incomplete service sequence causes reset or interrupt, per mode.
// - Sticky flag records that the last reset came from the guard timer.
// - Tick clock divided by four drives a 24-bit down counter.
// - Timeout values below 0xFF load 0xFF into the counter.
// - Interval spans 256x4 to 2^24x4 tick periods in steps of four.
// - Tick clock selects free-running oscillator 2 MHz or external clock.
package sgt_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0]  CTRL_OFS    = 8'h00;
	localparam logic [7:0]  TMO_OFS     = 8'h04;
	localparam logic [7:0]  FEED_OFS    = 8'h08;
	localparam logic [7:0]  COUNT_OFS   = 8'h0C;
	localparam logic [7:0]  STAT_OFS    = 8'h10;
	localparam logic [7:0]  MASK_OFS    = 8'h14;
	localparam logic [7:0]  CLKSEL_OFS  = 8'h18;

	// ----------------------------------------
	// Fields and values
	// ----------------------------------------
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_MODE_BIT = 1;
	localparam int          ST_TMO_BIT    = 0;
	localparam int          ST_FEED_BIT   = 1;
	localparam int          ST_FLAG_BIT   = 2;
	localparam int          CNT_W         = 24;
	localparam int          ST_W          = 3;
	localparam logic [23:0] TMO_RST       = 24'hFFFFFF;
	localparam logic [23:0] MIN_LOAD      = 24'h0000FF;
	localparam logic [7:0]  FEED_KEY1     = 8'hAA;
	localparam logic [7:0]  FEED_KEY2     = 8'h55;
	localparam logic [1:0]  PRESCALE_LAST = 2'h3;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : sgt_pkg

// ---- design/sgt_tick.sv ----
`timescale 1ns/1ps
module sgt_tick (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic sel,
	input  wire logic osc_clk,
	input  wire logic ext_clk,
	output logic      tick
);

	typedef struct packed {
		logic       osc_prev;
		logic       ext_prev;
		logic [1:0] div;
		logic       tick;
	} sgt_tick_t;

	sgt_tick_t s_q;
	sgt_tick_t s_d;
	logic      edge_seen;

	// ----------------------------------------
	// Source select and prescaler
	// ----------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.osc_prev = osc_clk;
		s_d.ext_prev = ext_clk;
		edge_seen    = sel ? (ext_clk & ~s_q.ext_prev) : (osc_clk & ~s_q.osc_prev);
		s_d.tick     = edge_seen && (s_q.div == sgt_pkg::PRESCALE_LAST);
		if (edge_seen) begin
			s_d.div = s_q.div + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

	property p_tick_spacing;
		@(posedge aclk) disable iff (!aresetn)
		s_q.tick |=> !s_q.tick [*3];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("prescaled ticks closer than four edges");

endmodule : sgt_tick

// ---- design/sgt_top.sv ----
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module sgt_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        por_n,
	input  wire logic        osc_clk,
	input  wire logic        ext_clk,
	input  wire logic        dbg_halt,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             irq,
	output logic             sys_reset_req
);

	typedef struct packed {
		logic        aw_full;
		logic [7:0]  aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        en;
		logic        rst_mode;
		logic        clk_sel;
		logic [23:0] tmo;
		logic [23:0] cnt;
		logic        armed;
		logic [2:0]  st;
		logic [2:0]  mask;
		logic        irq;
		logic        sys_rst;
	} sgt_state_t;

	localparam sgt_state_t S_RST = '{
		awready: 1'b1,
		wready:  1'b1,
		arready: 1'b1,
		tmo:     sgt_pkg::TMO_RST,
		default: '0
	};

	sgt_state_t  s_q;
	sgt_state_t  s_d;
	logic        tick;
	logic        wr_go;
	logic        rd_go;
	logic        load_go;
	logic        feed_ok;
	logic        feed_bad;
	logic        expire;
	logic        trip;
	logic [23:0] load_val;
	logic [31:0] wmerged;
	logic [2:0]  st_set;
	logic [2:0]  st_clr;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == sgt_pkg::CTRL_OFS) || (a == sgt_pkg::TMO_OFS) || (a == sgt_pkg::FEED_OFS)
			|| (a == sgt_pkg::COUNT_OFS) || (a == sgt_pkg::STAT_OFS) || (a == sgt_pkg::MASK_OFS)
			|| (a == sgt_pkg::CLKSEL_OFS);
	endfunction : addr_mapped

	function automatic logic [31:0] reg_value(input logic [7:0] a, input sgt_state_t s);
		reg_value = '0;
		unique case (a)
			sgt_pkg::CTRL_OFS:   reg_value = {30'h0, s.rst_mode, s.en};
			sgt_pkg::TMO_OFS:    reg_value = {8'h0, s.tmo};
			sgt_pkg::COUNT_OFS:  reg_value = {8'h0, s.cnt};
			sgt_pkg::STAT_OFS:   reg_value = {29'h0, s.st};
			sgt_pkg::MASK_OFS:   reg_value = {29'h0, s.mask};
			sgt_pkg::CLKSEL_OFS: reg_value = {31'h0, s.clk_sel};
			default:             reg_value = '0;
		endcase
	endfunction : reg_value

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	// ----------------------------------------
	// Tick source
	// ----------------------------------------
	sgt_tick sgt_tick_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sel     (s_q.clk_sel),
		.osc_clk (osc_clk),
		.ext_clk (ext_clk),
		.tick    (tick)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d      = s_q;
		wr_go    = s_q.aw_full && s_q.w_full && !s_q.bvalid;
		rd_go    = arvalid && s_q.arready;
		wmerged  = merge(reg_value(s_q.aw_addr, s_q), s_q.w_data, s_q.w_strb);
		load_val = (s_q.tmo < sgt_pkg::MIN_LOAD) ? sgt_pkg::MIN_LOAD : s_q.tmo;
		feed_ok  = 1'b0;
		feed_bad = 1'b0;
		load_go  = 1'b0;
		st_set   = '0;
		st_clr   = '0;

		// Address and data capture
		if (awvalid && s_q.awready) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && s_q.wready) begin
			s_d.w_full = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end

		// Register writes
		if (wr_go) begin
			s_d.aw_full = 1'b0;
			s_d.w_full  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = addr_mapped(s_q.aw_addr) ? sgt_pkg::RESP_OKAY : sgt_pkg::RESP_SLVERR;
			unique case (s_q.aw_addr)
				sgt_pkg::CTRL_OFS: begin
					if (!s_q.en) begin
						s_d.rst_mode = wmerged[sgt_pkg::CTRL_MODE_BIT];
						if (wmerged[sgt_pkg::CTRL_EN_BIT]) begin
							s_d.en  = 1'b1;
							load_go = 1'b1;
						end
					end
				end
				sgt_pkg::TMO_OFS: begin
					s_d.tmo = wmerged[23:0];
				end
				sgt_pkg::FEED_OFS: begin
					if (s_q.w_strb[0] && s_q.w_data[7:0] == sgt_pkg::FEED_KEY1) begin
						s_d.armed = 1'b1;
					end else if (s_q.w_strb[0] && s_q.w_data[7:0] == sgt_pkg::FEED_KEY2 && s_q.armed) begin
						s_d.armed = 1'b0;
						feed_ok   = s_q.en;
					end else begin
						s_d.armed = 1'b0;
						feed_bad  = s_q.en;
					end
				end
				sgt_pkg::STAT_OFS: begin
					st_clr = s_q.w_strb[0] ? s_q.w_data[2:0] : 3'h0;
				end
				sgt_pkg::MASK_OFS: begin
					s_d.mask = wmerged[2:0];
				end
				sgt_pkg::CLKSEL_OFS: begin
					s_d.clk_sel = wmerged[0];
				end
				default: begin
				end
			endcase
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		s_d.awready = !s_d.aw_full;
		s_d.wready  = !s_d.w_full;

		// Register reads
		if (rd_go) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = reg_value(araddr, s_q);
			s_d.rresp  = addr_mapped(araddr) ? sgt_pkg::RESP_OKAY : sgt_pkg::RESP_SLVERR;
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		s_d.arready = !s_d.rvalid;

		// Countdown
		expire = s_q.en && tick && !dbg_halt && (s_q.cnt == 24'h0);
		if (feed_ok) begin
			load_go = 1'b1;
		end
		if (load_go) begin
			s_d.cnt = load_val;
		end else if (s_q.en && tick && !dbg_halt && s_q.cnt != 24'h0) begin
			s_d.cnt = s_q.cnt - 24'h1;
		end

		// Expiry and bad service
		trip      = expire || feed_bad;
		s_d.sys_rst = trip && s_q.rst_mode;
		if (trip) begin
			s_d.en    = 1'b0;
			s_d.armed = 1'b0;
		end
		st_set[sgt_pkg::ST_TMO_BIT]  = expire;
		st_set[sgt_pkg::ST_FEED_BIT] = feed_bad;
		st_set[sgt_pkg::ST_FLAG_BIT] = trip && s_q.rst_mode;
		s_d.st  = (s_q.st & ~st_clr) | st_set;
		s_d.irq = |(s_d.st & s_d.mask);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!por_n) begin
			s_q <= S_RST;
		end else if (!aresetn) begin
			s_q                       <= S_RST;
			s_q.st[sgt_pkg::ST_FLAG_BIT] <= s_q.st[sgt_pkg::ST_FLAG_BIT];
		end else begin
			s_q <= s_d;
		end
	end

	assign awready       = s_q.awready;
	assign wready        = s_q.wready;
	assign bvalid        = s_q.bvalid;
	assign bresp         = s_q.bresp;
	assign arready       = s_q.arready;
	assign rvalid        = s_q.rvalid;
	assign rdata         = s_q.rdata;
	assign rresp         = s_q.rresp;
	assign irq           = s_q.irq;
	assign sys_reset_req = s_q.sys_rst;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_expire_reset;
		@(posedge aclk) disable iff (!aresetn)
		(expire && s_q.rst_mode) |=> sys_reset_req;
	endproperty
	a_expire_reset: assert property (p_expire_reset) else $error("expiry without reset request");

	property p_en_sticky;
		@(posedge aclk) disable iff (!aresetn)
		$fell(s_q.en) |-> $past(expire || feed_bad);
	endproperty
	a_en_sticky: assert property (p_en_sticky) else $error("enable dropped without cause");

	property p_bad_feed;
		@(posedge aclk) disable iff (!aresetn)
		feed_bad |=> (sys_reset_req == $past(s_q.rst_mode)) && s_q.st[sgt_pkg::ST_FEED_BIT] && !s_q.en;
	endproperty
	a_bad_feed: assert property (p_bad_feed) else $error("bad service not acted on");

	property p_flag_set;
		@(posedge aclk) disable iff (!aresetn)
		$rose(sys_reset_req) |-> s_q.st[sgt_pkg::ST_FLAG_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("reset flag missing");

	property p_count_dec;
		@(posedge aclk) disable iff (!aresetn)
		(tick && s_q.en && !dbg_halt && s_q.cnt != 24'h0 && !load_go) |=> s_q.cnt == $past(s_q.cnt) - 24'h1;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("counter did not decrement");

	property p_min_load;
		@(posedge aclk) disable iff (!aresetn)
		load_go |=> s_q.cnt >= 24'h0000FF;
	endproperty
	a_min_load: assert property (p_min_load) else $error("load below minimum");

	property p_no_early_expire;
		@(posedge aclk) disable iff (!aresetn)
		load_go |=> !expire [*8];
	endproperty
	a_no_early_expire: assert property (p_no_early_expire) else $error("expired too soon after load");

	property p_feed_reload;
		@(posedge aclk) disable iff (!aresetn)
		feed_ok |=> s_q.cnt == (($past(s_q.tmo) < 24'h0000FF) ? 24'h0000FF : $past(s_q.tmo));
	endproperty
	a_feed_reload: assert property (p_feed_reload) else $error("service did not reload");

endmodule : sgt_top

// ---- verification/system_guard_timer_tb.sv ----
`timescale 1ns/1ps
module system_guard_timer_tb;
	logic        aclk, aresetn, por_n, osc_clk, ext_clk, dbg_halt;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, irq, sys_reset_req;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          bad_count, checks, cyc, n, t;
	logic [7:0]  k;
	logic [3:0]  be;
	int          st_q[$];

	sgt_top sgt_top_inst (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .osc_clk(osc_clk),
		.ext_clk(ext_clk), .dbg_halt(dbg_halt), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .sys_reset_req(sys_reset_req));

	// ----------------------------------------
	// Clocks and timeout
	// ----------------------------------------
	always #5 aclk = ~aclk;
	always #20 osc_clk = ~osc_clk;
	always #30 ext_clk = ~ext_clk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ta, tw;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		wstrb   <= be;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end while ((awvalid && !ta) || (wvalid && !tw));
		@(negedge aclk);
		while (bvalid !== 1'h1) @(negedge aclk);
		rs = bresp;
		@(posedge aclk);
		bready <= 1'h0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		@(negedge aclk);
		while (arready !== 1'h1) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'h0;
		@(negedge aclk);
		while (rvalid !== 1'h1) @(negedge aclk);
		v  = rdata;
		rs = rresp;
		@(posedge aclk);
		rready <= 1'h0;
	endtask : rd

	task wok(input logic [7:0] a, input logic [31:0] v);
		wr(a, v, r);
		chk({30'h0, r}, {30'h0, sgt_pkg::RESP_OKAY}, "write resp");
	endtask : wok

	task rchk(input logic [7:0] a, input logic [31:0] e, input string m);
		rd(a, d, r);
		chk({30'h0, r}, {30'h0, sgt_pkg::RESP_OKAY}, "read resp");
		chk(d, e, m);
	endtask : rchk

	task meas(input bit use_rst, output int c);
		c = 0;
		@(negedge aclk);
		while ((use_rst ? sys_reset_req : irq) !== 1'h1) begin
			@(negedge aclk);
			c++;
		end
	endtask : meas

	// Model: counter load value, never below the minimum
	function automatic int load_of(int tmo);
		return (tmo < int'(sgt_pkg::MIN_LOAD)) ? int'(sgt_pkg::MIN_LOAD) : tmo;
	endfunction : load_of

	// Model: load+1 ticks, p aclk cycles per tick
	function automatic bit near(int c, int tmo, int p);
		int e;
		e = (load_of(tmo) + 1) * p;
		return (c >= e - p - 6) && (c <= e + p + 6);
	endfunction : near

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{aclk, osc_clk, ext_clk, aresetn, por_n, dbg_halt} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{cyc, bad_count, checks} = 0;
		be = 4'hF;
		void'($urandom(32'h3124ebf3));
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		por_n   <= 1'h1;
		rchk(sgt_pkg::CTRL_OFS, 32'h0, "ctrl reset");
		rchk(sgt_pkg::TMO_OFS, 32'h00FFFFFF, "timeout reset");
		st_q.push_back(0);
		rchk(sgt_pkg::STAT_OFS, 32'(st_q.pop_front()), "status reset");
		rd(8'h1C, d, r);
		chk({30'h0, r}, {30'h0, sgt_pkg::RESP_SLVERR}, "unmapped read");
		chk(d, 32'h0, "unmapped data");
		wr(8'h1C, 32'h1, r);
		chk({30'h0, r}, {30'h0, sgt_pkg::RESP_SLVERR}, "unmapped write");
		// Byte strobes merge into the timeout word
		be <= 4'h3;
		wok(sgt_pkg::TMO_OFS, 32'h00123456);
		be <= 4'hF;
		rchk(sgt_pkg::TMO_OFS, 32'h00FF3456, "byte strobes");
		// Minimum load, sticky enable, decrement, feed
		dbg_halt <= 1'h1;
		wok(sgt_pkg::TMO_OFS, 32'h10);
		wok(sgt_pkg::MASK_OFS, 32'h2);
		wok(sgt_pkg::CTRL_OFS, 32'h1);
		rchk(sgt_pkg::COUNT_OFS, 32'(load_of(32'h10)), "min load");
		wok(sgt_pkg::CTRL_OFS, 32'h0);
		rchk(sgt_pkg::CTRL_OFS, 32'h1, "enable sticks");
		dbg_halt <= 1'h0;
		repeat (200) @(posedge aclk);
		dbg_halt <= 1'h1;
		rd(sgt_pkg::COUNT_OFS, d, r);
		chk(32'(d >= 32'hF0 && d <= 32'hF5), 32'h1, "prescaled decrement");
		wok(sgt_pkg::FEED_OFS, {24'h0, sgt_pkg::FEED_KEY1});
		wok(sgt_pkg::FEED_OFS, {24'h0, sgt_pkg::FEED_KEY2});
		rchk(sgt_pkg::COUNT_OFS, 32'(load_of(32'h10)), "feed reload");
		k = 8'($urandom_range(0, 255));
		if (k == sgt_pkg::FEED_KEY1) k = 8'h12;
		wok(sgt_pkg::FEED_OFS, {24'h0, k});
		st_q.push_back(2);
		repeat (2) @(negedge aclk);
		chk({31'h0, irq}, 32'h1, "bad feed irq");
		chk({31'h0, sys_reset_req}, 32'h0, "no reset in irq mode");
		rchk(sgt_pkg::STAT_OFS, 32'(st_q.pop_front()), "bad feed status");
		rchk(sgt_pkg::CTRL_OFS, 32'h0, "irq clears enable");
		wok(sgt_pkg::STAT_OFS, 32'h2);
		repeat (2) @(negedge aclk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		@(posedge aclk);
		dbg_halt <= 1'h0;
		// External tick clock, random timeout
		t = int'($urandom_range(0, 32'h1FF));
		wok(sgt_pkg::CLKSEL_OFS, 32'h1);
		wok(sgt_pkg::MASK_OFS, 32'h1);
		wok(sgt_pkg::TMO_OFS, 32'(t));
		wok(sgt_pkg::CTRL_OFS, 32'h1);
		meas(1'h0, n);
		chk(32'(near(n, t, 24)), 32'h1, "ext clock interval");
		st_q.push_back(1);
		rchk(sgt_pkg::STAT_OFS, 32'(st_q.pop_front()), "expiry status");
		// Reset mode on oscillator clock
		wok(sgt_pkg::STAT_OFS, 32'h1);
		wok(sgt_pkg::CLKSEL_OFS, 32'h0);
		wok(sgt_pkg::MASK_OFS, 32'h0);
		wok(sgt_pkg::TMO_OFS, 32'h180);
		wok(sgt_pkg::CTRL_OFS, 32'h3);
		meas(1'h1, n);
		chk(32'(near(n, 32'h180, 16)), 32'h1, "reset interval");
		@(negedge aclk);
		chk({31'h0, sys_reset_req}, 32'h0, "reset pulse width");
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		st_q.push_back(4);
		rchk(sgt_pkg::STAT_OFS, 32'(st_q.pop_front()), "guard reset flag");
		rchk(sgt_pkg::CTRL_OFS, 32'h0, "reset clears enable");
		wok(sgt_pkg::STAT_OFS, 32'h4);
		st_q.push_back(0);
		rchk(sgt_pkg::STAT_OFS, 32'(st_q.pop_front()), "flag cleared");
		tally_and_finish();
	end
endmodule : system_guard_timer_tb
